// ---- common/tsq_cfg.svh ----
// Purpose: Constants of the test access port sequencer
// Assumes: Included by its bare name from the package and the design files
// Notes: Codes are 8 bits wide, shifted least significant bit first
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH

`define TSQ_IR_W 8
`define TSQ_DR_W 8
`define TSQ_IR_CAPTURE 8'h81
`define TSQ_IR_BYPASS 8'hFF
`define TSQ_IR_USER 8'h01
`define TSQ_BYPASS_CAPTURE 1'h0
`define TSQ_SYNC_STAGES 2

`endif

// ---- common/tsq_pkg.sv ----
// Purpose: Types shared by the test access port sequencer
// Assumes: tsq_cfg.svh supplies the widths
// Notes: State codes are the usual four-bit controller codes
`include "tsq_cfg.svh"

package tsq_pkg;

    typedef enum logic [3:0] {
        ST_RESET    = 4'hF,
        ST_IDLE     = 4'hC,
        ST_SEL_DR   = 4'h7,
        ST_CAP_DR   = 4'h6,
        ST_SHIFT_DR = 4'h2,
        ST_EXIT1_DR = 4'h1,
        ST_PAUSE_DR = 4'h3,
        ST_EXIT2_DR = 4'h0,
        ST_UPD_DR   = 4'h5,
        ST_SEL_IR   = 4'h4,
        ST_CAP_IR   = 4'hE,
        ST_SHIFT_IR = 4'hA,
        ST_EXIT1_IR = 4'h9,
        ST_PAUSE_IR = 4'hB,
        ST_EXIT2_IR = 4'h8,
        ST_UPD_IR   = 4'hD
    } tsq_state_e;

    typedef struct packed {
        logic [`TSQ_IR_W-1:0] instr;
        logic [`TSQ_DR_W-1:0] data;
    } tsq_xfer_s;

endpackage

// ---- rtl/tsq_sync2.sv ----
// Purpose: Multi-stage level synchroniser into the clock given
// Assumes: Each bit is a slow level or a toggle, never a bus that changes as a whole
// Notes: No reset, so the stages settle within STAGES edges of a running clock
`timescale 1ns/1ps
`include "tsq_cfg.svh"

module tsq_sync2 #(
    parameter int WIDTH = 1,
    parameter int STAGES = `TSQ_SYNC_STAGES
) (
    // Destination clock
    input wire logic clk,
    // Level from the foreign domain
    input wire logic [WIDTH-1:0] din,
    // Synchronised level
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage_q [STAGES];
    logic [WIDTH-1:0] stage_d [STAGES];

    always_comb begin
        stage_d[0] = din;
        for (int i = 1; i < STAGES; i++) begin
            stage_d[i] = stage_q[i-1];
        end
    end

    // The first stage feeds only the next stage
    always_ff @(posedge clk) begin
        for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= stage_d[i];
        end
    end

    assign dout = stage_q[STAGES-1];

endmodule

// ---- rtl/tsq_tap.sv ----
// Purpose: Test access port with instruction register, bypass and one user data register
// Assumes: tck from the scan controller, tms and tdi synchronous to it; rst on mclk
// Notes: Rising tck samples, falling tck drives; updates are copied to the mclk side
//
// Summary of operation
// - The instruction shift register loads 10000001 on the rising edge leaving instruction capture.
// - The serial output driver turns on at the falling edge after a shift state is entered.
// - Each rising edge in instruction shift moves one bit in from serial input and one bit out.
// - In either exit1 state the serial output returns to high impedance at the falling edge.
// - In instruction update the shifted code moves into the active instruction at the falling edge.
// - An all-ones instruction selects the bypass register.
// - With bypass selected, the bypass stage loads zero on the rising edge leaving data capture.
// - Bypass delays the serial stream by exactly one stage.
// - In data update the selected data register's parallel output loads at the falling edge.
// - Serial input, mode select and parallel inputs are sampled rising; tck-domain outputs change falling, sys_xfer on rising mclk.
`timescale 1ns/1ps
`include "tsq_cfg.svh"

module tsq_tap (
    // System clock domain
    input wire logic mclk,
    input wire logic rst,
    // Test port, test clock domain
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_en,
    // Normal-function pins, test clock domain
    input wire logic [`TSQ_DR_W-1:0] par_in,
    output logic [`TSQ_DR_W-1:0] par_out,
    // Latest update as seen on mclk
    output tsq_pkg::tsq_xfer_s sys_xfer,
    output logic sys_xfer_valid
);

    function automatic logic is_user(input logic [`TSQ_IR_W-1:0] code);
        is_user = (code == `TSQ_IR_USER);
    endfunction

    logic trst;
    logic ack_s;
    logic req_s;

    // Reset only acts while tck runs; a stopped tck keeps its state
    tsq_sync2 #(.WIDTH(1)) u_rst_sync (.clk(tck), .din(rst), .dout(trst));

    // Rising-edge group: controller and shift stages
    tsq_pkg::tsq_state_e state_q, state_d;
    logic [`TSQ_IR_W-1:0] ir_sh_q, ir_sh_d;
    logic [`TSQ_DR_W-1:0] dr_sh_q, dr_sh_d;
    logic bypass_q, bypass_d;
    logic [`TSQ_IR_W-1:0] ir_act_q, ir_act_d;
    logic user_sel;

    assign user_sel = is_user(ir_act_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            tsq_pkg::ST_RESET: state_d = tms ? tsq_pkg::ST_RESET : tsq_pkg::ST_IDLE;
            tsq_pkg::ST_IDLE: state_d = tms ? tsq_pkg::ST_SEL_DR : tsq_pkg::ST_IDLE;
            tsq_pkg::ST_SEL_DR: state_d = tms ? tsq_pkg::ST_SEL_IR : tsq_pkg::ST_CAP_DR;
            tsq_pkg::ST_CAP_DR: state_d = tms ? tsq_pkg::ST_EXIT1_DR : tsq_pkg::ST_SHIFT_DR;
            tsq_pkg::ST_SHIFT_DR: state_d = tms ? tsq_pkg::ST_EXIT1_DR : tsq_pkg::ST_SHIFT_DR;
            tsq_pkg::ST_EXIT1_DR: state_d = tms ? tsq_pkg::ST_UPD_DR : tsq_pkg::ST_PAUSE_DR;
            tsq_pkg::ST_PAUSE_DR: state_d = tms ? tsq_pkg::ST_EXIT2_DR : tsq_pkg::ST_PAUSE_DR;
            tsq_pkg::ST_EXIT2_DR: state_d = tms ? tsq_pkg::ST_UPD_DR : tsq_pkg::ST_SHIFT_DR;
            tsq_pkg::ST_UPD_DR: state_d = tms ? tsq_pkg::ST_SEL_DR : tsq_pkg::ST_IDLE;
            tsq_pkg::ST_SEL_IR: state_d = tms ? tsq_pkg::ST_RESET : tsq_pkg::ST_CAP_IR;
            tsq_pkg::ST_CAP_IR: state_d = tms ? tsq_pkg::ST_EXIT1_IR : tsq_pkg::ST_SHIFT_IR;
            tsq_pkg::ST_SHIFT_IR: state_d = tms ? tsq_pkg::ST_EXIT1_IR : tsq_pkg::ST_SHIFT_IR;
            tsq_pkg::ST_EXIT1_IR: state_d = tms ? tsq_pkg::ST_UPD_IR : tsq_pkg::ST_PAUSE_IR;
            tsq_pkg::ST_PAUSE_IR: state_d = tms ? tsq_pkg::ST_EXIT2_IR : tsq_pkg::ST_PAUSE_IR;
            tsq_pkg::ST_EXIT2_IR: state_d = tms ? tsq_pkg::ST_UPD_IR : tsq_pkg::ST_SHIFT_IR;
            tsq_pkg::ST_UPD_IR: state_d = tms ? tsq_pkg::ST_SEL_DR : tsq_pkg::ST_IDLE;
            default: state_d = tsq_pkg::ST_RESET;
        endcase
    end

    always_comb begin
        ir_sh_d = ir_sh_q;
        dr_sh_d = dr_sh_q;
        bypass_d = bypass_q;
        case (state_q)
            tsq_pkg::ST_CAP_IR: ir_sh_d = `TSQ_IR_CAPTURE;
            tsq_pkg::ST_SHIFT_IR: ir_sh_d = {tdi, ir_sh_q[`TSQ_IR_W-1:1]};
            tsq_pkg::ST_CAP_DR: begin
                if (user_sel) begin
                    dr_sh_d = par_in;
                end else begin
                    bypass_d = `TSQ_BYPASS_CAPTURE;
                end
            end
            tsq_pkg::ST_SHIFT_DR: begin
                if (user_sel) begin
                    dr_sh_d = {tdi, dr_sh_q[`TSQ_DR_W-1:1]};
                end else begin
                    bypass_d = tdi;
                end
            end
            default: ir_sh_d = ir_sh_q;
        endcase
    end

    always_ff @(posedge tck) begin
        if (trst) begin
            state_q <= tsq_pkg::ST_RESET;
            ir_sh_q <= `TSQ_IR_CAPTURE;
            dr_sh_q <= '0;
            bypass_q <= `TSQ_BYPASS_CAPTURE;
        end else begin
            state_q <= state_d;
            ir_sh_q <= ir_sh_d;
            dr_sh_q <= dr_sh_d;
            bypass_q <= bypass_d;
        end
    end

    // Falling-edge group: pin drivers, active instruction, parallel output, hand-off
    logic tdo_q, tdo_d;
    logic tdo_en_q, tdo_en_d;
    logic [`TSQ_DR_W-1:0] par_out_q, par_out_d;
    logic pend_q, pend_d;
    logic req_q, req_d;
    tsq_pkg::tsq_xfer_s xfer_q, xfer_d;
    logic upd_now;
    logic launch;
    logic shifting;

    assign shifting = (state_q == tsq_pkg::ST_SHIFT_IR) || (state_q == tsq_pkg::ST_SHIFT_DR);
    assign upd_now = (state_q == tsq_pkg::ST_UPD_IR) || (state_q == tsq_pkg::ST_UPD_DR);
    // Next word waits until the mclk side has acknowledged the previous one
    assign launch = pend_q && (req_q == ack_s) && !upd_now;

    always_comb begin
        tdo_en_d = shifting;
        tdo_d = tdo_q;
        if (state_q == tsq_pkg::ST_SHIFT_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (state_q == tsq_pkg::ST_SHIFT_DR) begin
            tdo_d = user_sel ? dr_sh_q[0] : bypass_q;
        end
        ir_act_d = ir_act_q;
        if (state_q == tsq_pkg::ST_RESET) begin
            ir_act_d = `TSQ_IR_BYPASS;
        end else if (state_q == tsq_pkg::ST_UPD_IR) begin
            ir_act_d = ir_sh_q;
        end
        par_out_d = par_out_q;
        if (state_q == tsq_pkg::ST_UPD_DR && user_sel) begin
            par_out_d = dr_sh_q;
        end
        // A new update wins over the launch of an older one
        pend_d = upd_now || (pend_q && !launch);
        req_d = launch ? !req_q : req_q;
        xfer_d = xfer_q;
        if (launch) begin
            xfer_d.instr = ir_act_q;
            xfer_d.data = par_out_q;
        end
    end

    always_ff @(negedge tck) begin
        if (trst) begin
            tdo_q <= 1'h0;
            tdo_en_q <= 1'h0;
            ir_act_q <= `TSQ_IR_BYPASS;
            par_out_q <= '0;
            pend_q <= 1'h0;
            req_q <= 1'h0;
            xfer_q <= '0;
        end else begin
            tdo_q <= tdo_d;
            tdo_en_q <= tdo_en_d;
            ir_act_q <= ir_act_d;
            par_out_q <= par_out_d;
            pend_q <= pend_d;
            req_q <= req_d;
            xfer_q <= xfer_d;
        end
    end

    assign tdo = tdo_q;
    assign tdo_en = tdo_en_q;
    assign par_out = par_out_q;

    // System group: toggle handshake, xfer_q holds still until ack returns
    logic ack_q, ack_d;
    tsq_pkg::tsq_xfer_s sys_q, sys_d;
    logic valid_q, valid_d;

    tsq_sync2 #(.WIDTH(1)) u_req_sync (.clk(mclk), .din(req_q), .dout(req_s));
    tsq_sync2 #(.WIDTH(1)) u_ack_sync (.clk(tck), .din(ack_q), .dout(ack_s));

    always_comb begin
        ack_d = req_s;
        valid_d = (req_s != ack_q);
        sys_d = valid_d ? xfer_q : sys_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'h0;
            sys_q <= '0;
            valid_q <= 1'h0;
        end else begin
            ack_q <= ack_d;
            sys_q <= sys_d;
            valid_q <= valid_d;
        end
    end

    assign sys_xfer = sys_q;
    assign sys_xfer_valid = valid_q;

    // Checks on the test clock domain, with one cover on mclk
    property p_ir_capture;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_CAP_IR |=> ir_sh_q == `TSQ_IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("IR capture value wrong");

    property p_oe_on;
        @(negedge tck) disable iff (trst)
        (state_q == tsq_pkg::ST_SHIFT_IR || state_q == tsq_pkg::ST_SHIFT_DR) |=> tdo_en_q;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("Serial output not enabled in shift");

    property p_ir_shift;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_SHIFT_IR |=> ir_sh_q == {$past(tdi), $past(ir_sh_q[`TSQ_IR_W-1:1])};
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("IR did not shift one bit");

    property p_oe_off;
        @(negedge tck) disable iff (trst)
        (state_q == tsq_pkg::ST_EXIT1_IR || state_q == tsq_pkg::ST_EXIT1_DR) |=> !tdo_en_q;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("Serial output still driven in exit1");

    property p_ir_update;
        @(negedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_UPD_IR |=> ir_act_q == $past(ir_sh_q);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("Instruction not updated");

    // Watches the update itself, so a wrong decode of the shifted ones is caught
    property p_bypass_sel;
        @(negedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_UPD_IR && ir_sh_q == `TSQ_IR_BYPASS
        |=> ir_act_q == `TSQ_IR_BYPASS && !user_sel;
    endproperty
    a_bypass_sel: assert property (p_bypass_sel) else $error("All ones did not select bypass");

    property p_bypass_cap;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_CAP_DR && !user_sel |=> bypass_q == `TSQ_BYPASS_CAPTURE;
    endproperty
    a_bypass_cap: assert property (p_bypass_cap) else $error("Bypass did not capture zero");

    property p_bypass_delay;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_SHIFT_DR && !user_sel ##1 state_q == tsq_pkg::ST_SHIFT_DR
        |-> bypass_q == $past(tdi) && tdo_q == $past(tdi);
    endproperty
    a_bypass_delay: assert property (p_bypass_delay) else $error("Bypass delay not one stage");

    property p_dr_update;
        @(negedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_UPD_DR && user_sel |=> par_out_q == $past(dr_sh_q);
    endproperty
    a_dr_update: assert property (p_dr_update) else $error("Parallel output not updated");

    property p_par_sample;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_CAP_DR && user_sel |=> dr_sh_q == $past(par_in);
    endproperty
    a_par_sample: assert property (p_par_sample) else $error("Parallel input not sampled");

    property p_tms_reset;
        @(posedge tck) disable iff (trst)
        (state_q == tsq_pkg::ST_UPD_DR && tms) ##1 tms [*2] |=> state_q == tsq_pkg::ST_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("Three ones from update missed reset");

    property p_five_ones;
        @(posedge tck) disable iff (trst)
        tms [*5] |=> state_q == tsq_pkg::ST_RESET;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("Five ones did not reach reset");

    property p_ir_scan_done;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_UPD_IR;
    endproperty
    c_ir_scan_done: cover property (p_ir_scan_done);

    property p_bypass_scan;
        @(posedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_SHIFT_DR && !user_sel ##1 state_q == tsq_pkg::ST_EXIT1_DR;
    endproperty
    c_bypass_scan: cover property (p_bypass_scan);

    property p_user_update;
        @(negedge tck) disable iff (trst)
        state_q == tsq_pkg::ST_UPD_DR && user_sel;
    endproperty
    c_user_update: cover property (p_user_update);

    property p_sys_copy;
        @(posedge mclk) disable iff (rst)
        valid_q;
    endproperty
    c_sys_copy: cover property (p_sys_copy);

endmodule

// ---- sim/tsq_scan_ctl.sv ----
// Purpose: Scan controller model driving the test port
// Assumes: The caller chooses the state path; one call is one test clock cycle
// Notes: The test clock rests low between calls, as a real controller stops it
`timescale 1ns/1ps

module tsq_scan_ctl (
    // Test port, driven
    output logic tck,
    output logic tms,
    output logic tdi,
    // Test port, observed
    input wire logic tdo_w,
    input wire logic tdo_en
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Inputs move only while the clock is low, 5 ns ahead of the rising edge
    task automatic cycle(input logic m, input logic d, output logic pre_en, output logic q);
        tms = m;
        tdi = d;
        #5 tck = 1'b1;
        #1 pre_en = tdo_en;
        #5 tck = 1'b0;
        #1 q = tdo_w;
    endtask
endmodule

// ---- sim/tsq_tap_bench.sv ----
// Purpose: Self-checking bench of the test access port
// Assumes: Scan controller model supplies the test clock at 12 ns
// Notes: Idle data-in toggles so a stale level is never mistaken for shifted data
`timescale 1ns/1ps
`include "tsq_cfg.svh"

module tsq_tap_bench;
    logic mclk;
    logic rst;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_en;
    logic [7:0] par_in;
    logic [7:0] par_out;
    tsq_pkg::tsq_xfer_s sys_xfer;
    tsq_pkg::tsq_xfer_s last_xfer;
    logic sys_xfer_valid;
    wire tdo_w;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic pre;
    logic q;

    // Released serial output floats
    assign tdo_w = tdo_en ? tdo : 1'bz;

    tsq_tap uut (
        .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_en(tdo_en),
        .par_in(par_in), .par_out(par_out), .sys_xfer(sys_xfer), .sys_xfer_valid(sys_xfer_valid)
    );

    tsq_scan_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w), .tdo_en(tdo_en));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard at 3000 mclk cycles, well above the roughly 60 mclk cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (sys_xfer_valid === 1'b1) begin
            last_xfer <= sys_xfer;
        end
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(input logic m);
        ctl.cycle(m, ~tdi, pre, q);
    endtask

    task automatic idle(input int n);
        repeat (n) step(1'b0);
    endtask

    // From idle or update to update, shifting n bits least significant first
    task automatic scan(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
        dout = 8'h00;
        step(1'b1);
        if (ir) begin
            step(1'b1);
        end
        step(1'b0);
        ctl.cycle(1'b0, ~tdi, pre, q);
        check({7'h00, pre}, 8'h00);
        check({7'h00, tdo_en}, 8'h01);
        dout[0] = q;
        for (int i = 0; i < n; i++) begin
            ctl.cycle(i == n - 1, din[i], pre, q);
            if (i < n - 1) begin
                dout[i+1] = q;
            end
        end
        check({7'h00, q}, {7'h00, 1'bz});
        step(1'b1);
    endtask

    // Room for two handshake round trips when an update arrives while one is in flight
    task automatic xfer_check(input logic [7:0] instr, input logic [7:0] data);
        idle(30);
        check(last_xfer.instr, instr);
        check(last_xfer.data, data);
    endtask

    task automatic t_ir_bypass();
        logic [7:0] d;
        step(1'b0);
        scan(1'b1, 8'hFF, 8, d);
        check(d, 8'h81);
        scan(1'b0, 8'h05, 3, d);
        check({5'h00, d[2:0]}, 8'h02);
        xfer_check(8'hFF, 8'h00);
        $display("test ir_bypass done");
    endtask

    task automatic t_user_dr();
        logic [7:0] d;
        par_in = 8'hA5;
        scan(1'b1, `TSQ_IR_USER, 8, d);
        check(d, 8'h81);
        scan(1'b0, 8'h3C, 8, d);
        check(d, 8'hA5);
        check(par_out, 8'h3C);
        xfer_check(`TSQ_IR_USER, 8'h3C);
        $display("test user_dr done");
    endtask

    // Back-to-back user scan, then out to reset, which must restore bypass
    task automatic t_reset_return();
        logic [7:0] d;
        scan(1'b0, 8'h00, 8, d);
        check(d, 8'hA5);
        check(par_out, 8'h00);
        repeat (3) step(1'b1);
        step(1'b0);
        scan(1'b0, 8'h05, 3, d);
        check({5'h00, d[2:0]}, 8'h02);
        // Leave the user register by an all-ones scan rather than by reset
        scan(1'b1, `TSQ_IR_USER, 8, d);
        scan(1'b1, 8'hFF, 8, d);
        check(d, 8'h81);
        scan(1'b0, 8'h05, 3, d);
        check({5'h00, d[2:0]}, 8'h02);
        $display("test reset_return done");
    endtask

    initial begin
        rst = 1'b1;
        par_in = 8'h00;
        last_xfer = '0;
        // Test clock must run during reset for its synchroniser
        fork
            repeat (6) @(posedge mclk);
            repeat (18) ctl.cycle(1'b1, 1'b0, pre, q);
        join
        #2 rst = 1'b0;
        repeat (8) step(1'b1);
        check({7'h00, tdo_en}, 8'h00);
        t_ir_bypass();
        t_user_dr();
        t_reset_return();
        conclude();
    end
endmodule
